// ---- bench/long_term_predict_pulse_coder_tb.sv ----
/*
 * Self-checking bench of the long-term predictor and pulse coder.
 * Assumes the far-side model ltp_partner handles input and return traffic.
 */
`timescale 1ns/1ns
module long_term_predict_pulse_coder_tb;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic in_valid, in_ready, resid_valid, recon_valid, recon_ready;
	logic signed [15:0] in_data, resid_data, recon_data;
	logic param_valid, pulse_valid;
	logic [6:0] lag_code;
	logic [1:0] gain_code, grid_code, sub_index, c_gain, c_grid, c_sub;
	logic [5:0] max_code, c_max;
	logic [6:0] c_lag;
	logic [2:0] pulse_code;
	logic [2:0] pul [13];
	int n_pv = 0;
	int n_mismatch = 0;
	int cmp_count = 0;

	always #5 clk = ~clk;

	ltp_pulse_coder #(.DW(16)) dut (.clk(clk), .nrst(nrst), .in_valid(in_valid),
		.in_data(in_data), .in_ready(in_ready), .resid_valid(resid_valid),
		.resid_data(resid_data), .recon_valid(recon_valid), .recon_data(recon_data),
		.recon_ready(recon_ready), .param_valid(param_valid), .lag_code(lag_code),
		.gain_code(gain_code), .grid_code(grid_code), .max_code(max_code),
		.pulse_valid(pulse_valid), .pulse_code(pulse_code), .sub_index(sub_index));

	ltp_partner pm (.clk(clk), .nrst(nrst), .in_ready(in_ready), .in_valid(in_valid),
		.in_data(in_data), .resid_valid(resid_valid), .resid_data(resid_data),
		.recon_ready(recon_ready), .recon_valid(recon_valid), .recon_data(recon_data));

	// capture each parameter set and its pulses
	always @(posedge clk) begin
		if (param_valid) begin
			c_lag = lag_code;
			c_gain = gain_code;
			c_grid = grid_code;
			c_max = max_code;
			c_sub = sub_index;
			n_pv = 0;
		end
		if (pulse_valid && n_pv < 13)
			pul[n_pv] = pulse_code;
		if (pulse_valid)
			n_pv = n_pv + 1;
	end

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk_code(input string nm, input logic [6:0] exp, input logic [6:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %0d seen %0d", nm, exp, got);
		end
	endtask

	task automatic chk_smp(input string nm, input logic signed [15:0] exp,
		input logic signed [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %0d seen %0d", nm, exp, got);
		end
	endtask

	task automatic do_reset();
		nrst <= 1'b0;
		pm.n_req <= 0;
		pm.stall <= 0;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
	endtask

	task automatic fill(input int pos, input logic signed [15:0] v);
		for (int k = 0; k < 40; k++)
			pm.src[k] = 16'sh0000;
		pm.src[pos] = v;
	endtask

	// one sub-segment through load, coding and return, bounded wait
	task automatic run_sub();
		int d0;
		d0 = pm.n_done;
		pm.n_req <= pm.n_req + 1;
		for (int t = 0; t < 6000 && pm.n_done == d0; t++)
			@(posedge clk);
		if (pm.n_done == d0) begin
			n_mismatch++;
			close_out();
		end
		repeat (2) @(posedge clk);
	endtask

	// outputs during reset: in_ready high, recon_ready, both valids and sub_index low
	task automatic t_reset();
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk_code("in_ready", 7'h01, {6'h00, in_ready});
		chk_code("recon_ready", 7'h00, {6'h00, recon_ready});
		chk_code("param_valid", 7'h00, {6'h00, param_valid});
		chk_code("pulse_valid", 7'h00, {6'h00, pulse_valid});
		chk_code("sub_index", 7'h00, {5'h00, sub_index});
		do_reset();
	endtask

	// silent sub-segments: ties keep lag 40 and grid 0, index wraps
	task automatic t_zero();
		fill(0, 16'sh0000);
		for (int n = 0; n < 5; n++) begin
			run_sub();
			chk_code("sub_index", 7'(n % 4), {5'h00, c_sub});
			chk_code("lag", 7'h28, c_lag);
			chk_code("gain", 7'h00, {5'h00, c_gain});
			chk_code("grid", 7'h00, {5'h00, c_grid});
			chk_code("max", 7'h00, {1'b0, c_max});
			chk_code("pulse_count", 7'h0d, 7'(n_pv));
			chk_code("pulse", 7'h04, {4'h0, pul[12]});
		end
	endtask

	// single impulse: weighting centre lands on grid 2, pulse 6
	task automatic t_impulse();
		int vv [7] = '{31, 32, 512, 4096, 32767, -32, -8192};
		int mc [7] = '{0, 1, 16, 40, 63, 1, 48};
		int pc [7] = '{7, 6, 7, 7, 7, 1, 0};
		for (int n = 0; n < 7; n++) begin
			do_reset();
			fill(20, 16'(vv[n]));
			run_sub();
			chk_smp("resid", 16'(vv[n]), pm.res[20]);
			chk_code("grid", 7'h02, {5'h00, c_grid});
			chk_code("max", 7'(mc[n]), {1'b0, c_max});
			chk_code("pulse", 7'(pc[n]), {4'h0, pul[6]});
			chk_code("pulse", 7'h04, {4'h0, pul[0]});
		end
	endtask

	// second sub-segment predicts from the first at lag 50
	task automatic t_ltp();
		int vb [6] = '{200, 201, 500, 501, 800, 801};
		int gc [6] = '{0, 1, 1, 2, 2, 3};
		logic signed [31:0] pr;
		for (int n = 0; n < 6; n++) begin
			do_reset();
			fill(20, 16'sh03e8);
			run_sub();
			fill(30, 16'(vb[n]));
			// return held back past entry to the return phase
			pm.stall <= 600;
			run_sub();
			pr = (32'(ltp_pkg::GAIN_LEV[gc[n]]) * 1000 + 16384) >>> 15;
			chk_code("lag", 7'h32, c_lag);
			chk_code("gain", 7'(gc[n]), {5'h00, c_gain});
			chk_code("sub_index", 7'h01, {5'h00, c_sub});
			chk_smp("resid", 16'(vb[n] - pr), pm.res[30]);
			chk_smp("resid", 16'sh0000, pm.res[29]);
			chk_smp("history", 16'sh03e8, dut.hist[60]);
			chk_smp("recon", 16'(vb[n]), dut.hist[110]);
		end
	endtask

	initial begin
		do_reset();
		t_reset();
		t_zero();
		t_impulse();
		t_ltp();
		close_out();
	end
endmodule

// ---- bench/ltp_partner.sv ----
/*
 * Far-side model: feeds 40-sample residual sub-segments from src and
 * returns each captured long-term residual as the reconstructed one.
 * Assumes the bench sets src, n_req and stall by hierarchical reference.
 */
`timescale 1ns/1ns
module ltp_partner (
	input wire logic clk,
	input wire logic nrst,
	input wire logic in_ready,
	output logic in_valid,
	output logic signed [15:0] in_data,
	input wire logic resid_valid,
	input wire logic signed [15:0] resid_data,
	input wire logic recon_ready,
	output logic recon_valid,
	output logic signed [15:0] recon_data
);
	logic signed [15:0] src [40];
	logic signed [15:0] res [40];
	int n_req = 0;
	int stall = 0;
	int in_k, n_in, rs_k, rc_k, n_done, wait_c;
	logic got;

	// offer samples while sub-segments are requested; hold until taken
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			in_valid <= 1'b0;
			in_data <= 16'sh0000;
			in_k = 0;
			n_in = 0;
		end else begin
			if (in_valid && in_ready) begin
				in_k = in_k + 1;
				if (in_k == 40) begin
					in_k = 0;
					n_in = n_in + 1;
				end
			end
			in_valid <= (n_in < n_req);
			// idle line toggles so a stale value never looks valid
			in_data <= (n_in < n_req) ? src[in_k] : ~in_data;
		end
	end

	// capture residual, return it after an optional stall
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			recon_valid <= 1'b0;
			recon_data <= 16'sh0000;
			rs_k = 0;
			rc_k = 0;
			n_done = 0;
			got = 1'b0;
			wait_c = 0;
		end else begin
			if (resid_valid) begin
				res[rs_k] = resid_data;
				rs_k = rs_k + 1;
				if (rs_k == 40) begin
					rs_k = 0;
					got = 1'b1;
					wait_c = stall;
				end
			end
			if (recon_valid && recon_ready) begin
				rc_k = rc_k + 1;
				if (rc_k == 40) begin
					rc_k = 0;
					got = 1'b0;
					n_done = n_done + 1;
				end
			end
			if (got && wait_c > 0)
				wait_c = wait_c - 1;
			recon_valid <= got && wait_c == 0;
			recon_data <= (got && wait_c == 0) ? res[rc_k] : ~recon_data;
		end
	end
endmodule

// ---- inc/ltp_pkg.sv ----
/*
 * Shared constants of the long-term predictor and pulse coder: sub-segment
 * geometry, lag range, weighting taps, gain levels and block-maximum steps.
 * Assumes 16-bit two's complement samples throughout.
 */
package ltp_pkg;

	// geometry of a sub-segment and its history
	localparam int SUB_LEN = 40;
	localparam int SUBS = 4;
	localparam int HIST_LEN = 120;
	localparam int LAG_MIN = 40;
	localparam int LAG_MAX = 120;

	// weighting filter, taps scaled by 2^13
	localparam int TAPS = 11;
	localparam int TAP_MID = 5;
	localparam int W_SHIFT = 13;
	localparam logic signed [15:0] H_TAP [TAPS] = '{
		-16'sh0086, -16'sh0176, 16'sh0000, 16'sh0806, 16'sh166d, 16'sh2000,
		16'sh166d, 16'sh0806, 16'sh0000, -16'sh0176, -16'sh0086};

	// gain decision levels in tenths, reconstruction levels scaled by 2^15
	localparam int GAIN_DEC_DEN = 10;
	localparam int GAIN_DEC_NUM [3] = '{2, 5, 8};
	localparam int G_SHIFT = 15;
	localparam logic signed [15:0] GAIN_LEV [4] = '{
		16'sh0ccd, 16'sh2ccd, 16'sh5333, 16'sh7fff};

	// decimation grid and pulse coding
	localparam int NGRID = 4;
	localparam int DEC = 3;
	localparam int NPULSE = 13;
	localparam int PULSE_MID = 4;

	// block maximum: linear codes, then doubling segments of eight codes
	localparam int MAXC_LIN = 16;
	localparam int MAXC_NUM = 64;
	localparam int LIN_STEP = 32;
	localparam int SEG_BASE = 512;
	localparam int SEG_LEN = 8;
	localparam int SEG_STEP = 64;

	typedef enum logic [3:0] {
		S_LOAD, S_CORR, S_NRG, S_GAIN, S_LTAF, S_WGT, S_GRID, S_MAX, S_QNT, S_REC
	} state_e;

endpackage

// ---- src/apcm_quant.sv ----
/*
 * Block-maximum log coder and 3-bit uniform pulse quantizer, purely
 * combinational. Assumes xmax is the non-negative largest magnitude,
 * at most 32767, and that |sample| does not exceed it.
 */
`timescale 1ns/1ns
module apcm_quant (
	input wire logic [15:0] xmax,
	input wire logic signed [15:0] sample,
	output logic [5:0] max_code,
	output logic [15:0] max_dec,
	output logic [2:0] pulse
);

	// upper bound of the interval that a block-maximum code stands for
	function automatic logic [15:0] max_upper(input logic [5:0] c);
		logic [5:0] r;
		r = c - 6'(ltp_pkg::MAXC_LIN);
		if (c < 6'(ltp_pkg::MAXC_LIN))
			max_upper = 16'(({10'h000, c} + 16'h0001) * 16'(ltp_pkg::LIN_STEP) - 16'h0001);
		else
			max_upper = 16'((32'(ltp_pkg::SEG_BASE) << r[5:3])
				+ ((32'(ltp_pkg::SEG_STEP) << r[5:3]) * (32'(r[2:0]) + 32'h1)) - 32'h1);
	endfunction

	// smallest code whose interval still holds the maximum
	always_comb begin
		logic [6:0] cnt;
		cnt = '0;
		for (int c = 0; c < ltp_pkg::MAXC_NUM; c++) begin
			if (max_upper(6'(c)) < xmax)
				cnt = cnt + 7'h01;
		end
		max_code = cnt[5:0];
		max_dec = max_upper(cnt[5:0]);
	end

	// compare 4*x against multiples of the decoded maximum: steps a quarter of max_dec wide
	always_comb begin
		logic signed [19:0] x4;
		logic signed [19:0] dm;
		logic [2:0] up;
		logic [2:0] dn;
		x4 = 20'(sample) * 20'sh00004;
		dm = 20'(signed'({1'b0, max_dec}));
		up = '0;
		dn = '0;
		for (int t = 1; t < ltp_pkg::PULSE_MID; t++) begin
			if (x4 >= dm * 20'(t))
				up = up + 3'h1;
			if (x4 < -(dm * 20'(t)))
				dn = dn + 3'h1;
		end
		if (sample >= 0)
			pulse = 3'(ltp_pkg::PULSE_MID) + up;
		else
			pulse = 3'(ltp_pkg::PULSE_MID - 1) - dn;
	end

endmodule

// ---- src/ltp_pulse_coder.sv ----
/*
 * Long-term prediction and pulse coding of one 40-sample sub-segment at a
 * time: lag search, gain coding, analysis and synthesis filtering, block
 * weighting, grid selection and pulse quantization. Assumes the short-term
 * residual arrives on in_valid/in_ready, that the reconstructed long-term
 * residual comes back on recon_valid/recon_ready, and that the parameter
 * packer takes every output pulse without stalling.
 */
`timescale 1ns/1ns
module ltp_pulse_coder #(
	parameter int DW = 16
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic in_valid,
	input wire logic signed [15:0] in_data,
	output logic in_ready,
	output logic resid_valid,
	output logic signed [15:0] resid_data,
	input wire logic recon_valid,
	input wire logic signed [15:0] recon_data,
	output logic recon_ready,
	output logic param_valid,
	output logic [6:0] lag_code,
	output logic [1:0] gain_code,
	output logic [1:0] grid_code,
	output logic [5:0] max_code,
	output logic pulse_valid,
	output logic [2:0] pulse_code,
	output logic [1:0] sub_index
);

	if (DW != 16) begin : g_dw_check
		$error("only 16-bit samples are supported");
	end

	localparam logic [5:0] I_LAST = 6'(ltp_pkg::SUB_LEN - 1);
	localparam logic [3:0] T_TAP = 4'(ltp_pkg::TAPS - 1);
	localparam logic [3:0] T_PUL = 4'(ltp_pkg::NPULSE - 1);

	ltp_pkg::state_e state_q;
	logic [5:0] i_q;
	logic [3:0] t_q;
	logic [1:0] m_q;
	logic [6:0] lag_q;
	logic [1:0] sub_q;
	logic signed [15:0] hist [ltp_pkg::HIST_LEN];
	logic signed [15:0] d_mem [ltp_pkg::SUB_LEN];
	logic signed [15:0] e_mem [ltp_pkg::SUB_LEN];
	logic signed [15:0] p_mem [ltp_pkg::SUB_LEN];
	logic signed [15:0] x_mem [ltp_pkg::SUB_LEN];
	logic signed [47:0] acc_q, best_r_q, nrg_q, best_e_q;
	logic [6:0] best_lag_q;
	logic [1:0] gain_q, grid_q;
	logic [15:0] xmax_q;
	logic signed [15:0] mul_a, mul_b, gsamp, pred, e_val, dp, x_new, qsamp;
	logic signed [31:0] prod;
	logic signed [47:0] sum;
	logic [15:0] absv;
	logic [1:0] gcode;
	logic [5:0] q_max_code;
	logic [15:0] q_max_dec;
	logic [2:0] q_pulse;
	logic i_last;
	logic [7:0] res_cnt, pul_cnt;

	// history slot of the sample that lies lag earlier than position i
	function automatic logic [6:0] hidx(input logic [5:0] i, input logic [6:0] lag);
		hidx = 7'(ltp_pkg::HIST_LEN + int'(i) - int'(lag));
	endfunction

	// position of pulse j on grid m
	function automatic logic [5:0] gidx(input logic [1:0] m, input logic [3:0] j);
		gidx = 6'(int'(m) + ltp_pkg::DEC * int'(j));
	endfunction

	// clamp to the 16-bit sample range
	function automatic logic signed [15:0] sat16(input logic signed [47:0] v);
		if (v > 48'sh007fff)
			sat16 = 16'sh7fff;
		else if (v < -48'sh008000)
			sat16 = -16'sh8000;
		else
			sat16 = 16'(v);
	endfunction

	assign i_last = (i_q == I_LAST);
	assign in_ready = (state_q == ltp_pkg::S_LOAD);
	assign recon_ready = (state_q == ltp_pkg::S_REC);
	assign sub_index = sub_q;

	// shared multiplier: operands depend on the phase
	always_comb begin
		int w;
		w = int'(i_q) + ltp_pkg::TAP_MID - int'(t_q);
		mul_a = '0;
		mul_b = '0;
		unique case (state_q)
			ltp_pkg::S_CORR: begin
				mul_a = d_mem[i_q];
				mul_b = hist[hidx(i_q, lag_q)];
			end
			ltp_pkg::S_NRG: begin
				mul_a = hist[hidx(i_q, best_lag_q)];
				mul_b = hist[hidx(i_q, best_lag_q)];
			end
			ltp_pkg::S_WGT: begin
				mul_a = ltp_pkg::H_TAP[t_q];
				if (w >= 0 && w < ltp_pkg::SUB_LEN)
					mul_b = e_mem[6'(w)];
			end
			ltp_pkg::S_GRID: begin
				mul_a = x_mem[gidx(m_q, t_q)];
				mul_b = x_mem[gidx(m_q, t_q)];
			end
			ltp_pkg::S_LOAD, ltp_pkg::S_GAIN, ltp_pkg::S_LTAF, ltp_pkg::S_MAX,
			ltp_pkg::S_QNT, ltp_pkg::S_REC: begin
			end
		endcase
		prod = mul_a * mul_b;
		sum = acc_q + 48'(prod);
	end

	// gain decision, prediction, residual, reconstruction and weighting output
	always_comb begin
		logic signed [47:0] r10;
		logic signed [31:0] pr;
		r10 = best_r_q * 48'(ltp_pkg::GAIN_DEC_DEN);
		gcode = '0;
		if (nrg_q <= 0)
			gcode = (best_r_q > 0) ? 2'h3 : 2'h0;
		else
			for (int g = 0; g < 3; g++)
				if (r10 > nrg_q * 48'(ltp_pkg::GAIN_DEC_NUM[g]))
					gcode = gcode + 2'h1;
		gsamp = hist[hidx(i_q, best_lag_q)];
		pr = ltp_pkg::GAIN_LEV[gain_q] * gsamp;
		pred = sat16((48'(pr) + 48'sh004000) >>> ltp_pkg::G_SHIFT);
		e_val = sat16(48'(d_mem[i_q]) - 48'(pred));
		dp = sat16(48'(recon_data) + 48'(p_mem[i_q]));
		x_new = sat16((sum + 48'sh001000) >>> ltp_pkg::W_SHIFT);
		qsamp = x_mem[gidx(grid_q, t_q)];
		absv = (qsamp == -16'sh8000) ? 16'h7fff : 16'(qsamp < 0 ? -qsamp : qsamp);
	end

	apcm_quant u_quant (
		.xmax(xmax_q),
		.sample(qsamp),
		.max_code(q_max_code),
		.max_dec(q_max_dec),
		.pulse(q_pulse)
	);

	// sequencing of the phases of one sub-segment
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= ltp_pkg::S_LOAD;
		end else begin
			unique case (state_q)
				ltp_pkg::S_LOAD: if (in_valid && i_last) state_q <= ltp_pkg::S_CORR;
				ltp_pkg::S_CORR:
					if (i_last && lag_q == 7'(ltp_pkg::LAG_MAX)) state_q <= ltp_pkg::S_NRG;
				ltp_pkg::S_NRG: if (i_last) state_q <= ltp_pkg::S_GAIN;
				ltp_pkg::S_GAIN: state_q <= ltp_pkg::S_LTAF;
				ltp_pkg::S_LTAF: if (i_last) state_q <= ltp_pkg::S_WGT;
				ltp_pkg::S_WGT: if (i_last && t_q == T_TAP) state_q <= ltp_pkg::S_GRID;
				ltp_pkg::S_GRID: if (m_q == 2'h3 && t_q == T_PUL) state_q <= ltp_pkg::S_MAX;
				ltp_pkg::S_MAX: if (t_q == T_PUL) state_q <= ltp_pkg::S_QNT;
				ltp_pkg::S_QNT: if (t_q == T_PUL) state_q <= ltp_pkg::S_REC;
				ltp_pkg::S_REC: if (recon_valid && i_last) state_q <= ltp_pkg::S_LOAD;
			endcase
		end
	end

	// sample, tap, grid, lag and sub-segment counters
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			i_q <= '0;
			t_q <= '0;
			m_q <= '0;
			lag_q <= 7'(ltp_pkg::LAG_MIN);
			sub_q <= '0;
		end else begin
			unique case (state_q)
				ltp_pkg::S_LOAD, ltp_pkg::S_REC: begin
					if ((state_q == ltp_pkg::S_LOAD) ? in_valid : recon_valid)
						i_q <= i_last ? 6'h00 : i_q + 6'h01;
					if (state_q == ltp_pkg::S_REC && recon_valid && i_last)
						sub_q <= sub_q + 2'h1;
					lag_q <= 7'(ltp_pkg::LAG_MIN);
				end
				ltp_pkg::S_CORR: begin
					i_q <= i_last ? 6'h00 : i_q + 6'h01;
					if (i_last)
						lag_q <= lag_q + 7'h01;
				end
				ltp_pkg::S_NRG, ltp_pkg::S_LTAF: i_q <= i_last ? 6'h00 : i_q + 6'h01;
				ltp_pkg::S_GAIN: begin
				end
				ltp_pkg::S_WGT: begin
					t_q <= (t_q == T_TAP) ? 4'h0 : t_q + 4'h1;
					if (t_q == T_TAP)
						i_q <= i_last ? 6'h00 : i_q + 6'h01;
				end
				ltp_pkg::S_GRID, ltp_pkg::S_MAX, ltp_pkg::S_QNT: begin
					t_q <= (t_q == T_PUL) ? 4'h0 : t_q + 4'h1;
					if (state_q == ltp_pkg::S_GRID && t_q == T_PUL)
						m_q <= m_q + 2'h1;
				end
			endcase
		end
	end

	// accumulations, peak search, grid search and block maximum
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			acc_q <= '0;
			best_r_q <= '0;
			best_lag_q <= 7'(ltp_pkg::LAG_MIN);
			nrg_q <= '0;
			gain_q <= '0;
			best_e_q <= '0;
			grid_q <= '0;
			xmax_q <= '0;
		end else begin
			unique case (state_q)
				ltp_pkg::S_CORR: begin
					acc_q <= i_last ? 48'sh0 : sum;
					if (i_last && (lag_q == 7'(ltp_pkg::LAG_MIN) || sum > best_r_q)) begin
						best_r_q <= sum;
						best_lag_q <= lag_q;
					end
				end
				ltp_pkg::S_NRG: begin
					acc_q <= i_last ? 48'sh0 : sum;
					if (i_last)
						nrg_q <= sum;
				end
				ltp_pkg::S_GAIN: gain_q <= gcode;
				ltp_pkg::S_WGT: acc_q <= (t_q == T_TAP) ? 48'sh0 : sum;
				ltp_pkg::S_GRID: begin
					acc_q <= (t_q == T_PUL) ? 48'sh0 : sum;
					if (t_q == T_PUL && (m_q == 2'h0 || sum > best_e_q)) begin
						best_e_q <= sum;
						grid_q <= m_q;
					end
				end
				ltp_pkg::S_MAX:
					if (t_q == 4'h0 || absv > xmax_q)
						xmax_q <= absv;
				ltp_pkg::S_LOAD, ltp_pkg::S_LTAF, ltp_pkg::S_QNT, ltp_pkg::S_REC: begin
				end
			endcase
		end
	end

	// reconstructed history: one shift per returned sample keeps 120 past values
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int h = 0; h < ltp_pkg::HIST_LEN; h++)
				hist[h] <= '0;
		end else if (state_q == ltp_pkg::S_REC && recon_valid) begin
			for (int h = 0; h < ltp_pkg::HIST_LEN - 1; h++)
				hist[h] <= hist[h + 1];
			hist[ltp_pkg::HIST_LEN - 1] <= dp;
		end
	end

	// sub-segment working stores
	always_ff @(posedge clk) begin
		if (state_q == ltp_pkg::S_LOAD && in_valid)
			d_mem[i_q] <= in_data;
		if (state_q == ltp_pkg::S_LTAF) begin
			e_mem[i_q] <= e_val;
			p_mem[i_q] <= pred;
		end
		if (state_q == ltp_pkg::S_WGT && t_q == T_TAP)
			x_mem[i_q] <= x_new;
	end

	// registered outputs toward the packer
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			resid_valid <= 1'b0;
			resid_data <= '0;
			param_valid <= 1'b0;
			lag_code <= '0;
			gain_code <= '0;
			grid_code <= '0;
			max_code <= '0;
			pulse_valid <= 1'b0;
			pulse_code <= '0;
		end else begin
			resid_valid <= (state_q == ltp_pkg::S_LTAF);
			if (state_q == ltp_pkg::S_LTAF)
				resid_data <= e_val;
			param_valid <= (state_q == ltp_pkg::S_QNT && t_q == 4'h0);
			pulse_valid <= (state_q == ltp_pkg::S_QNT);
			if (state_q == ltp_pkg::S_QNT) begin
				pulse_code <= q_pulse;
				if (t_q == 4'h0) begin
					lag_code <= best_lag_q;
					gain_code <= gain_q;
					grid_code <= grid_q;
					max_code <= q_max_code;
				end
			end
		end
	end

	// helper counts of outputs in each sub-segment
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			res_cnt <= '0;
			pul_cnt <= '0;
		end else if (state_q == ltp_pkg::S_LOAD) begin
			res_cnt <= '0;
			pul_cnt <= '0;
		end else begin
			res_cnt <= res_cnt + 8'(resid_valid);
			pul_cnt <= pul_cnt + 8'(pulse_valid);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_lag_range:
		assert property (param_valid |-> lag_code >= 7'h28 && lag_code <= 7'h78)
		else $error("lag code outside 40..120");
	a_gain_negative:
		assert property (state_q == ltp_pkg::S_GAIN && best_r_q <= 0 |=> gain_q == 2'h0)
		else $error("non-positive peak did not give gain code 0");
	a_resid_count:
		assert property ($rose(state_q == ltp_pkg::S_WGT) |=> res_cnt == 8'h28)
		else $error("residual burst is not 40 samples");
	a_recon_hist:
		assert property (state_q == ltp_pkg::S_REC && recon_valid
			|=> hist[119] == sat16(48'($past(recon_data)) + 48'($past(p_mem[i_q]))))
		else $error("history not updated with reconstructed sample");
	a_pulse_count:
		assert property ($rose(state_q == ltp_pkg::S_REC) |=> pul_cnt == 8'h0d)
		else $error("pulse burst is not 13 codes");
	a_param_first:
		assert property (param_valid |-> pulse_valid ##1 !param_valid)
		else $error("parameters not aligned with first pulse");
	a_pulse_sign:
		assert property (state_q == ltp_pkg::S_QNT && qsamp >= 0 |=> pulse_code >= 3'h4)
		else $error("non-negative pulse coded below 4");
	a_max_cover:
		assert property (state_q == ltp_pkg::S_QNT |-> q_max_dec >= xmax_q)
		else $error("decoded maximum below block maximum");
	a_sub_step:
		assert property (state_q == ltp_pkg::S_REC && recon_valid && i_last
			|=> sub_q == $past(sub_q) + 2'h1 && state_q == ltp_pkg::S_LOAD)
		else $error("sub-segment index did not advance");

endmodule
